/* rtl/logic_trigger_qualifier.sv */
// Logic trigger decision block: timed pattern, state and setup/hold classes
`timescale 1ns/10ps
module logic_trigger_qualifier #(
  parameter int DUR_W = 24,
  parameter int SH_W = 8,
  parameter int HIST = 256,
  parameter int THR_W = 8,
  parameter int IDX_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Thresholded probe channels
  input wire logic [3:0] ch_in,
  // Register port
  input wire logic [trig_pkg::ADDR_W-1:0] addr,
  input wire logic [trig_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [trig_pkg::DATA_W-1:0] rd_data_r,
  // Threshold levels to the comparators
  output logic [THR_W-1:0] thr0_r,
  output logic [THR_W-1:0] thr1_r,
  output logic [THR_W-1:0] thr2_r,
  output logic [THR_W-1:0] thr3_r,
  // Trigger report
  output logic trig_r,
  output logic [IDX_W-1:0] trig_index_r
);

  // Evaluate one boolean function over enabled channels
  function automatic logic eval_logic(input logic [3:0] lvl, input logic [7:0] cond,
                                      input logic [3:0] use_ch, input logic [1:0] fn,
                                      input logic not_met);
    logic all_ok;
    logic any_ok;
    logic pre;
    logic [1:0] f;
    all_ok = 1'b1;
    any_ok = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (use_ch[i] && cond[2*i +: 2] != trig_pkg::COND_X) begin
        pre = (cond[2*i +: 2] == trig_pkg::COND_H) ? lvl[i] : ~lvl[i];
        all_ok = all_ok & pre;
        any_ok = any_ok | pre;
      end
    end
    // Not-met polarity swaps each function with its inverse
    f = fn ^ {not_met, 1'b0};
    case (f[0])
      1'b0: eval_logic = all_ok ^ f[trig_pkg::FN_INV_BIT];
      default: eval_logic = any_ok ^ f[trig_pkg::FN_INV_BIT];
    endcase
  endfunction

  // Build a mask of history bits lo..hi
  function automatic logic [HIST-1:0] range_mask(input int lo, input int hi);
    range_mask = '0;
    for (int i = 0; i < HIST; i++) begin
      if (i >= lo && i <= hi) begin
        range_mask[i] = 1'b1;
      end
    end
  endfunction

  // Configuration registers
  logic [1:0] class_r; // Active trigger class
  logic [1:0] func_r; // Selected logic function
  logic not_met_r; // Goes-false polarity
  logic longer_r; // Longer-than qualification
  logic st_fall_r; // State clock falling edge
  logic [1:0] dsrc_r; // Setup/hold data channel
  logic [1:0] csrc_r; // Setup/hold clock channel
  logic sh_fall_r; // Setup/hold clock falling edge
  logic [7:0] cond_r; // Per channel H/L/X
  logic [DUR_W-1:0] limit_r; // Duration limit in samples
  logic signed [SH_W-1:0] setup_r; // Setup in samples
  logic signed [SH_W-1:0] hold_r; // Hold in samples

  // Input synchronisers and edge history
  logic [3:0] sync1_r; // First stage, read only by second
  logic [3:0] sync2_r; // Stable channel levels
  logic [3:0] prev_r; // Levels one sample earlier
  logic [IDX_W-1:0] sample_r; // Free running sample index

  // Pattern duration measurement
  trig_pkg::pat_state_e pat_state_r;
  logic [DUR_W-1:0] dur_r; // Samples the function has been true
  logic [DUR_W-1:0] last_dur_r; // Last completed duration

  // Setup/hold history
  logic [HIST-2:0] trans_hist_r; // Data transitions, bit 0 newest
  logic [HIST-2:0] edge_hist_r; // Clock edges, bit 0 newest

  // Combinational decisions
  logic pat_now; // Pattern function this sample
  logic st_edge; // State clock edge this sample
  logic st_hit; // State condition at edge
  logic sh_hit; // Setup/hold violation found
  logic [IDX_W-1:0] sh_index; // Index of the edge that violated
  logic pat_hit; // Duration qualification passed
  logic [HIST-1:0] tnow; // Transition history incl. now
  logic [HIST-1:0] enow; // Edge history incl. now
  logic signed [SH_W:0] sum_sh; // Setup plus hold after a write
  logic [3:0] rise; // Rising edges per channel
  logic [3:0] fall; // Falling edges per channel

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // Two flip-flops before any logic sees a channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      sync1_r <= ch_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Sample index, one count per clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sample_r <= '0;
    end else begin
      sample_r <= sample_r + 1'b1;
    end
  end

  // Control register; defaults restored by reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      class_r <= trig_pkg::CLS_OFF;
      func_r <= trig_pkg::FN_AND;
      not_met_r <= 1'b0;
      longer_r <= 1'b0;
      st_fall_r <= 1'b0;
      dsrc_r <= trig_pkg::DSRC_RST;
      csrc_r <= trig_pkg::CSRC_RST;
      cond_r <= '0;
      limit_r <= '0;
    end else if (wr_stb) begin
      case (addr)
        trig_pkg::ADDR_CTRL: begin
          class_r <= wr_data[trig_pkg::CTRL_CLASS_LSB +: 2];
          func_r <= wr_data[trig_pkg::CTRL_FUNC_LSB +: 2];
          not_met_r <= wr_data[trig_pkg::CTRL_NOTMET_BIT];
          longer_r <= wr_data[trig_pkg::CTRL_LONGER_BIT];
          st_fall_r <= wr_data[trig_pkg::CTRL_STFALL_BIT];
          dsrc_r <= wr_data[trig_pkg::CTRL_DSRC_LSB +: 2];
          csrc_r <= wr_data[trig_pkg::CTRL_CSRC_LSB +: 2];
        end
        trig_pkg::ADDR_COND: begin
          cond_r <= wr_data[7:0];
        end
        trig_pkg::ADDR_LIMIT: begin
          limit_r <= wr_data[DUR_W-1:0];
        end
        default: begin
          // Other addresses leave control alone
        end
      endcase
    end
  end

  // Proposed window if a setup or hold write stood alone
  always_comb begin
    if (addr == trig_pkg::ADDR_SETUP) begin
      sum_sh = $signed(wr_data[SH_W-1:0]) + hold_r;
    end else begin
      sum_sh = setup_r + $signed(wr_data[SH_W-1:0]);
    end
  end

  // Setup and hold; a short window pushes the other value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      setup_r <= SH_W'(trig_pkg::MIN_WIN_CYC);
      hold_r <= '0;
    end else if (wr_stb && addr == trig_pkg::ADDR_SETUP) begin
      setup_r <= $signed(wr_data[SH_W-1:0]);
      if (sum_sh < trig_pkg::MIN_WIN_CYC) begin
        hold_r <= SH_W'(trig_pkg::MIN_WIN_CYC - $signed(wr_data[SH_W-1:0]));
      end
    end else if (wr_stb && addr == trig_pkg::ADDR_HOLD) begin
      hold_r <= $signed(wr_data[SH_W-1:0]);
      if (sum_sh < trig_pkg::MIN_WIN_CYC) begin
        setup_r <= SH_W'(trig_pkg::MIN_WIN_CYC - $signed(wr_data[SH_W-1:0]));
      end
    end
  end

  // Edge toggle command for the setup/hold clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_fall_r <= 1'b0;
    end else if (wr_stb && addr == trig_pkg::ADDR_CMD && wr_data[trig_pkg::CMD_TOGGLE_BIT]) begin
      sh_fall_r <= ~sh_fall_r;
    end
  end

  // Thresholds: one per channel, family presets load them all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thr0_r <= THR_W'(trig_pkg::THR_RST);
      thr1_r <= THR_W'(trig_pkg::THR_RST);
      thr2_r <= THR_W'(trig_pkg::THR_RST);
      thr3_r <= THR_W'(trig_pkg::THR_RST);
    end else if (wr_stb && addr == trig_pkg::ADDR_CMD && wr_data[trig_pkg::CMD_TTL_BIT]) begin
      thr0_r <= THR_W'(trig_pkg::THR_TTL);
      thr1_r <= THR_W'(trig_pkg::THR_TTL);
      thr2_r <= THR_W'(trig_pkg::THR_TTL);
      thr3_r <= THR_W'(trig_pkg::THR_TTL);
    end else if (wr_stb && addr == trig_pkg::ADDR_CMD && wr_data[trig_pkg::CMD_ECL_BIT]) begin
      thr0_r <= THR_W'(trig_pkg::THR_ECL);
      thr1_r <= THR_W'(trig_pkg::THR_ECL);
      thr2_r <= THR_W'(trig_pkg::THR_ECL);
      thr3_r <= THR_W'(trig_pkg::THR_ECL);
    end else if (wr_stb) begin
      // Independent levels decide each channel's logic state
      case (addr)
        trig_pkg::ADDR_THR0: thr0_r <= wr_data[THR_W-1:0];
        trig_pkg::ADDR_THR0 + 4'h1: thr1_r <= wr_data[THR_W-1:0];
        trig_pkg::ADDR_THR0 + 4'h2: thr2_r <= wr_data[THR_W-1:0];
        trig_pkg::ADDR_THR0 + 4'h3: thr3_r <= wr_data[THR_W-1:0];
        default: begin
          // Not a threshold
        end
      endcase
    end
  end

  // Pattern function over all four channels
  assign pat_now = eval_logic(sync2_r, cond_r, 4'hf, func_r, not_met_r);

  // Pattern duration FSM: time the true interval, judge on fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pat_state_r <= trig_pkg::PAT_WAIT;
      dur_r <= '0;
      last_dur_r <= '0;
    end else if (class_r != trig_pkg::CLS_PATTERN) begin
      pat_state_r <= trig_pkg::PAT_WAIT;
      dur_r <= '0;
    end else begin
      case (pat_state_r)
        trig_pkg::PAT_WAIT: begin
          if (pat_now) begin
            pat_state_r <= trig_pkg::PAT_TIMING;
            dur_r <= DUR_W'(1);
          end
        end
        trig_pkg::PAT_TIMING: begin
          if (!pat_now) begin
            pat_state_r <= trig_pkg::PAT_WAIT;
            last_dur_r <= dur_r;
          end else if (dur_r != '1) begin
            // Saturate so a long true interval still reads longer
            dur_r <= dur_r + 1'b1;
          end
        end
        default: begin
          pat_state_r <= trig_pkg::PAT_WAIT;
        end
      endcase
    end
  end

  // Duration judged only at the false transition
  always_comb begin
    pat_hit = 1'b0;
    if (class_r == trig_pkg::CLS_PATTERN && pat_state_r == trig_pkg::PAT_TIMING && !pat_now) begin
      if (longer_r) begin
        pat_hit = dur_r > limit_r;
      end else begin
        pat_hit = dur_r < limit_r;
      end
    end
  end

  // State class: channel four clocks the other three
  assign st_edge = st_fall_r ? fall[trig_pkg::STATE_CLK_CH] : rise[trig_pkg::STATE_CLK_CH];
  assign st_hit = st_edge && eval_logic(sync2_r, cond_r, 4'h7, func_r, not_met_r);

  // Setup/hold histories, bit 0 the previous sample
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trans_hist_r <= '0;
      edge_hist_r <= '0;
    end else begin
      trans_hist_r <= tnow[HIST-2:0];
      edge_hist_r <= enow[HIST-2:0];
    end
  end

  // Decide an edge once its hold span has passed
  always_comb begin
    int hp;
    int lo;
    int hi;
    hp = 0;
    lo = 0;
    hi = 0;
    tnow = {trans_hist_r, sync2_r[dsrc_r] ^ prev_r[dsrc_r]};
    // Edge where the clock crosses its level in the chosen direction
    enow = {edge_hist_r, sh_fall_r ? fall[csrc_r] : rise[csrc_r]};
    hp = (hold_r > 0) ? int'(hold_r) : 0;
    lo = hp - int'(hold_r);
    hi = hp + int'(setup_r);
    if (hi > HIST - 1) begin
      hi = HIST - 1;
    end
    sh_index = sample_r - IDX_W'(hp);
    // Same channel for data and clock would never see a clean edge
    sh_hit = class_r == trig_pkg::CLS_SETHOLD && dsrc_r != csrc_r && enow[hp] &&
             |(tnow & range_mask(lo, hi));
  end

  // One-cycle trigger pulse with its sample index
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_r <= 1'b0;
      trig_index_r <= '0;
    end else begin
      trig_r <= pat_hit || sh_hit || (class_r == trig_pkg::CLS_STATE && st_hit);
      if (pat_hit || (class_r == trig_pkg::CLS_STATE && st_hit)) begin
        trig_index_r <= sample_r;
      end else if (sh_hit) begin
        trig_index_r <= sh_index;
      end
    end
  end

  // Read data, registered so it stands the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= '0;
    end else if (rd_stb) begin
      rd_data_r <= '0;
      case (addr)
        trig_pkg::ADDR_CTRL: begin
          rd_data_r[trig_pkg::CTRL_CLASS_LSB +: 2] <= class_r;
          rd_data_r[trig_pkg::CTRL_FUNC_LSB +: 2] <= func_r;
          rd_data_r[trig_pkg::CTRL_NOTMET_BIT] <= not_met_r;
          rd_data_r[trig_pkg::CTRL_LONGER_BIT] <= longer_r;
          rd_data_r[trig_pkg::CTRL_STFALL_BIT] <= st_fall_r;
          rd_data_r[trig_pkg::CTRL_DSRC_LSB +: 2] <= dsrc_r;
          rd_data_r[trig_pkg::CTRL_CSRC_LSB +: 2] <= csrc_r;
          rd_data_r[trig_pkg::CTRL_SHFALL_BIT] <= sh_fall_r;
        end
        trig_pkg::ADDR_COND: rd_data_r[7:0] <= cond_r;
        trig_pkg::ADDR_LIMIT: rd_data_r[DUR_W-1:0] <= limit_r;
        trig_pkg::ADDR_SETUP: rd_data_r <= trig_pkg::DATA_W'(setup_r);
        trig_pkg::ADDR_HOLD: rd_data_r <= trig_pkg::DATA_W'(hold_r);
        trig_pkg::ADDR_THR0: rd_data_r[THR_W-1:0] <= thr0_r;
        trig_pkg::ADDR_THR0 + 4'h1: rd_data_r[THR_W-1:0] <= thr1_r;
        trig_pkg::ADDR_THR0 + 4'h2: rd_data_r[THR_W-1:0] <= thr2_r;
        trig_pkg::ADDR_THR0 + 4'h3: rd_data_r[THR_W-1:0] <= thr3_r;
        trig_pkg::ADDR_CMD: rd_data_r[trig_pkg::CMD_TOGGLE_BIT] <= sh_fall_r;
        trig_pkg::ADDR_STATUS: begin
          rd_data_r[0] <= pat_now;
          rd_data_r[1] <= pat_state_r == trig_pkg::PAT_TIMING;
          rd_data_r[5:2] <= sync2_r;
        end
        trig_pkg::ADDR_LASTDUR: rd_data_r[DUR_W-1:0] <= last_dur_r;
        default: begin
          // Unmapped addresses read zero
        end
      endcase
    end
  end

endmodule

/* rtl/trig_pkg.sv */
// Shared constants and types for the logic trigger qualifier
package trig_pkg;
  // Bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register word addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COND = 4'h1;
  localparam logic [3:0] ADDR_LIMIT = 4'h2;
  localparam logic [3:0] ADDR_SETUP = 4'h3;
  localparam logic [3:0] ADDR_HOLD = 4'h4;
  localparam logic [3:0] ADDR_THR0 = 4'h5;
  localparam logic [3:0] ADDR_CMD = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  localparam logic [3:0] ADDR_LASTDUR = 4'hb;
  // Control field positions
  localparam int CTRL_CLASS_LSB = 0;
  localparam int CTRL_FUNC_LSB = 2;
  localparam int CTRL_NOTMET_BIT = 4;
  localparam int CTRL_LONGER_BIT = 5;
  localparam int CTRL_STFALL_BIT = 6;
  localparam int CTRL_DSRC_LSB = 8;
  localparam int CTRL_CSRC_LSB = 10;
  localparam int CTRL_SHFALL_BIT = 12;
  // Command bits
  localparam int CMD_TOGGLE_BIT = 0;
  localparam int CMD_TTL_BIT = 1;
  localparam int CMD_ECL_BIT = 2;
  // Trigger classes
  localparam logic [1:0] CLS_OFF = 2'h0;
  localparam logic [1:0] CLS_PATTERN = 2'h1;
  localparam logic [1:0] CLS_STATE = 2'h2;
  localparam logic [1:0] CLS_SETHOLD = 2'h3;
  // Logic functions, bit 1 marks the inverted pair
  localparam logic [1:0] FN_AND = 2'h0;
  localparam logic [1:0] FN_OR = 2'h1;
  localparam int FN_INV_BIT = 1;
  // Channel conditions
  localparam logic [1:0] COND_X = 2'h0;
  localparam logic [1:0] COND_H = 2'h1;
  localparam logic [1:0] COND_L = 2'h2;
  // Reset values, threshold presets and the state clock channel
  localparam logic [1:0] DSRC_RST = 2'h0;
  localparam logic [1:0] CSRC_RST = 2'h1;
  localparam logic [7:0] THR_RST = 8'h80;
  localparam logic [7:0] THR_TTL = 8'h8c;
  localparam logic [7:0] THR_ECL = 8'h5a;
  localparam int STATE_CLK_CH = 3;
  // Timing
  localparam int CLK_NS = 20;
  localparam int MIN_WIN_NS = 2;
  localparam int MIN_WIN_RAW = (MIN_WIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_WIN_CYC = (MIN_WIN_RAW < 1) ? 1 : MIN_WIN_RAW;
  // Pattern duration measurement states
  typedef enum logic [0:0] {
    PAT_WAIT = 1'b0,
    PAT_TIMING = 1'b1
  } pat_state_e;
endpackage

/* verif/logic_trigger_qualifier_props.sv */
// Port-level assertion checker for the logic trigger qualifier
`timescale 1ns/10ps
module logic_trigger_qualifier_props #(
  parameter int DUR_W = 24,
  parameter int SH_W = 8,
  parameter int HIST = 256,
  parameter int THR_W = 8,
  parameter int IDX_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Probe channels
  input wire logic [3:0] ch_in,
  // Register port
  input wire logic [trig_pkg::ADDR_W-1:0] addr,
  input wire logic [trig_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [trig_pkg::DATA_W-1:0] rd_data_r,
  // Thresholds
  input wire logic [THR_W-1:0] thr0_r,
  input wire logic [THR_W-1:0] thr1_r,
  input wire logic [THR_W-1:0] thr2_r,
  input wire logic [THR_W-1:0] thr3_r,
  // Trigger report
  input wire logic trig_r,
  input wire logic [IDX_W-1:0] trig_index_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Mirror of the class field
  logic [1:0] cls_r;
  // Recent ch4 levels, wide enough to cover sync latency
  logic [4:0] c4_r;
  // Class mirror follows control writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cls_r <= trig_pkg::CLS_OFF;
    end else if (wr_stb && addr == trig_pkg::ADDR_CTRL) begin
      cls_r <= wr_data[1:0];
    end
  end
  // Ch4 history for the edge check
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c4_r <= 5'h0;
    end else begin
      c4_r <= {c4_r[3:0], ch_in[3]};
    end
  end
  a_unmapped_read: assert property (rd_stb && addr == 4'hc |=> rd_data_r == '0)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!rd_stb |=> $stable(rd_data_r))
    else $error("read data moved without a read");
  a_thr_write: assert property (wr_stb && addr == trig_pkg::ADDR_THR0 |=> thr0_r == $past(wr_data[THR_W-1:0]))
    else $error("threshold write lost");
  a_ttl_preset: assert property (wr_stb && addr == trig_pkg::ADDR_CMD && wr_data[trig_pkg::CMD_TTL_BIT]
    |=> {thr0_r, thr1_r, thr2_r, thr3_r} == {4{trig_pkg::THR_TTL}})
    else $error("ttl preset not applied");
  a_ecl_preset: assert property (wr_stb && addr == trig_pkg::ADDR_CMD && wr_data[2:1] == 2'h2
    |=> {thr0_r, thr1_r, thr2_r, thr3_r} == {4{trig_pkg::THR_ECL}})
    else $error("ecl preset not applied");
  a_thr_idle: assert property (!wr_stb |=> $stable({thr0_r, thr1_r, thr2_r, thr3_r}))
    else $error("threshold moved without a write");
  a_off_silent: assert property ((cls_r == trig_pkg::CLS_OFF)[*3] |-> !trig_r)
    else $error("trigger while class off");
  a_index_hold: assert property (!trig_r |-> $stable(trig_index_r))
    else $error("index moved without a trigger");
  a_state_clocked: assert property (trig_r && cls_r == trig_pkg::CLS_STATE |->
    c4_r[4:1] != 4'h0 && c4_r[4:1] != 4'hf)
    else $error("state trigger without ch4 edge");
endmodule

/* verif/probe_model.sv */
// Probe side model: data levels plus a bursty clock channel
`timescale 1ns/10ps
module probe_model (
  // Levels and clock control
  input wire logic [3:0] lvl,
  input wire logic [1:0] clk_ch,
  input wire logic run,
  // Thresholded channels
  output logic [3:0] ch
);
  // Probe clock, stands low between bursts
  logic pclk;
  // 160 ns period, offset so edges never meet core edges
  initial begin
    pclk = 1'b0;
    forever begin
      wait (run);
      #7 pclk = 1'b1;
      #80 pclk = 1'b0;
      #73;
    end
  end
  // Clock channel replaces that data level
  always_comb begin
    ch = lvl;
    ch[clk_ch] = pclk;
  end
endmodule

/* verif/test_logic_trigger_qualifier.sv */
// Self-checking bench for the logic trigger qualifier
`timescale 1ns/10ps
module test_logic_trigger_qualifier;
  // Clock, reset and register port
  logic core_clk;
  logic rst;
  logic [3:0] addr;
  logic [31:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rd_data_r;
  // Thresholds and trigger
  logic [7:0] thr0_r, thr1_r, thr2_r, thr3_r;
  logic trig_r;
  logic [31:0] trig_index_r;
  // Probe controls and channels
  logic [3:0] lvl;
  logic [1:0] clk_ch;
  logic run;
  wire [3:0] ch_in;
  // Counters and read scratch
  int fail_count = 0;
  int tests_run = 0;
  int trig_count = 0;
  logic [31:0] rv;
  // Bench sample count and index of the latest trigger
  int cyc = 0;
  logic [31:0] idx_seen;

  logic_trigger_qualifier logic_trigger_qualifier_i (.core_clk, .rst, .ch_in, .addr, .wr_data, .wr_stb,
    .rd_stb, .rd_data_r, .thr0_r, .thr1_r, .thr2_r, .thr3_r, .trig_r, .trig_index_r);
  probe_model probe_model_i (.lvl, .clk_ch, .run, .ch(ch_in));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Count trigger pulses and keep the index they carried
  always @(posedge core_clk) begin
    if (trig_r === 1'b1) begin
      trig_count++;
      idx_seen = trig_index_r;
    end
  end

  // One count per sample, restarted by reset like the block's own index
  always @(posedge core_clk) begin
    if (rst) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  // Read, data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data_r;
  endtask

  // Thresholds seen away from the edge
  task automatic thr_chk(input logic [31:0] e);
    @(negedge core_clk);
    chk("thresholds", e, {thr3_r, thr2_r, thr1_r, thr0_r});
  endtask

  // Reset and default checks
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    thr_chk({4{trig_pkg::THR_RST}});
    rd(trig_pkg::ADDR_CTRL, rv);
    chk("control", 32'h400, rv);
    rd(trig_pkg::ADDR_SETUP, rv);
    chk("setup", 32'h1, rv);
    rd(4'hc, rv);
    chk("unmapped", 32'h0, rv);
  endtask

  // Probe clock burst: two full periods, then idle
  task automatic burst();
    run <= 1'b1;
    repeat (15) @(posedge core_clk);
    run <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask

  // Timed pattern: ch1 high for w samples, limit 5
  task automatic pat_case(input logic longer, input int w, input logic exp);
    int t;
    wr(trig_pkg::ADDR_CTRL, {26'h0, longer, 3'h0, trig_pkg::CLS_PATTERN});
    trig_count = 0;
    lvl[0] <= 1'b1;
    repeat (w) @(posedge core_clk);
    // Count before this edge; the fall reaches the logic three samples on
    t = cyc;
    lvl[0] <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("early trigger", 0, trig_count);
    repeat (6) @(posedge core_clk);
    chk("pattern trigger", exp, trig_count);
    if (exp) chk("pattern index", t + 3, idx_seen);
    rd(trig_pkg::ADDR_LASTDUR, rv);
    chk("duration", w, rv);
  endtask

  // State class: ch1 H, ch2 L, ch3 X; falling edge when not met
  task automatic st_case(input logic [1:0] fn, input logic nm, input logic [3:0] d);
    logic c1, c2, f;
    c1 = d[0];
    c2 = !d[1];
    f = fn[0] ? (c1 | c2) : (c1 & c2);
    f = f ^ fn[1] ^ nm;
    wr(trig_pkg::ADDR_CTRL, {25'h0, nm, 1'b0, nm, fn, trig_pkg::CLS_STATE});
    lvl <= d;
    trig_count = 0;
    burst();
    chk("state triggers", f ? 2 : 0, trig_count);
  endtask

  // Setup/hold: data toggles one sample after a clock edge
  // ei: samples from the burst start to the last violating clock edge
  task automatic sh_case(input logic [7:0] s, input logic [7:0] h, input logic on_fall, input logic exp,
                         input int ei);
    int t;
    wr(trig_pkg::ADDR_SETUP, {24'h0, s});
    wr(trig_pkg::ADDR_HOLD, {24'h0, h});
    trig_count = 0;
    t = cyc;
    fork
      burst();
      repeat (2) begin
        if (on_fall) begin
          @(negedge ch_in[1]);
        end else begin
          @(posedge ch_in[1]);
        end
        @(posedge core_clk);
        lvl[0] <= ~lvl[0];
      end
    join
    chk("setup hold hit", exp, trig_count > 0);
    if (exp) chk("setup hold index", t + ei, idx_seen);
  endtask

  // Hang guard, about twenty times the planned run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wr_data = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    lvl = 4'h0;
    clk_ch = 2'h3;
    run = 1'b0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      wr(trig_pkg::ADDR_THR0 + 4'(i), 32'h11 * (i + 1));
    end
    thr_chk(32'h44332211);
    wr(trig_pkg::ADDR_CMD, 32'h4);
    thr_chk({4{trig_pkg::THR_ECL}});
    wr(trig_pkg::ADDR_CMD, 32'h6);
    thr_chk({4{trig_pkg::THR_TTL}});
    for (int i = 1; i < 3; i++) begin
      wr(trig_pkg::ADDR_CMD, 32'h1);
      rd(trig_pkg::ADDR_CMD, rv);
      chk("edge select", 32'(i % 2), rv & 32'h1);
    end
    wr(trig_pkg::ADDR_COND, 32'h1);
    wr(trig_pkg::ADDR_LIMIT, 32'h5);
    pat_case(1'b1, 10, 1'b1);
    pat_case(1'b1, 5, 1'b0);
    pat_case(1'b0, 4, 1'b1);
    pat_case(1'b0, 5, 1'b0);
    wr(trig_pkg::ADDR_COND, 32'h9);
    for (int f = 0; f < 8; f++) begin
      for (int d = 1; d < 4; d++) begin
        st_case(2'(f >> 1), 1'(f), 4'(d));
      end
    end
    clk_ch <= 2'h1;
    wr(trig_pkg::ADDR_CTRL, 32'h403);
    sh_case(8'h2, 8'h2, 1'b0, 1'b1, 11);
    sh_case(8'h2, 8'h2, 1'b1, 1'b0, 0);
    sh_case(8'h4, 8'hfe, 1'b0, 1'b0, 0);
    sh_case(8'h4, 8'hfe, 1'b1, 1'b1, 11);
    // Falling clock edge as reference: late data after each fall hits
    wr(trig_pkg::ADDR_CMD, 32'h1);
    sh_case(8'h2, 8'h2, 1'b1, 1'b1, 15);
    wr(trig_pkg::ADDR_SETUP, 32'hfe);
    rd(trig_pkg::ADDR_HOLD, rv);
    chk("hold adjusted", 32'h3, rv);
    wr(trig_pkg::ADDR_HOLD, 32'hfb);
    rd(trig_pkg::ADDR_SETUP, rv);
    chk("setup adjusted", 32'h6, rv);
    // Raise the mid-run reset on a clock edge like every other input
    @(posedge core_clk);
    do_reset();
    results();
  end
endmodule

bind logic_trigger_qualifier logic_trigger_qualifier_props #(.DUR_W(DUR_W), .SH_W(SH_W), .HIST(HIST),
  .THR_W(THR_W), .IDX_W(IDX_W)) logic_trigger_qualifier_props_i (.core_clk, .rst, .ch_in, .addr,
  .wr_data, .wr_stb, .rd_stb, .rd_data_r, .thr0_r, .thr1_r, .thr2_r, .thr3_r, .trig_r, .trig_index_r);
